//--- rtl/light_screen_ctrl.sv
// Configuration, reset and operating-state control for receiver and emitter
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Disagreeing redundant pairs at power-up cause lockout
// - Live change of receiver non-scan selectors causes lockout
// - Trip mode: outputs return on when clear
// - Latch mode: outputs stay off until reset
// - Left reduced-resolution position enables two-beam tolerance
// - Feedback selector picks one or two channel
// - Scan code 1 or 2, matched pairwise
// - Scan code change in run: no lockout
// - Aux output follows outputs or flags lockout
// - Two-channel monitoring disables aux output
// - Invert selector flips the digit display
// - Emitter input is reset or test
// - Emitter fault only when fault-enable on
// - Trip mode needs reset only after lockout
// - Latch: reset at power-up, latch, lockout
// - Lockout held until valid manual reset
// - Valid reset: closed 0.25 to 2 s, acts on opening
// - Closures over two seconds are ignored
// - Power cycle restarts from power-up state
// - Emitter led: red flash, green, blink green, blink red
// - Scan code flashed three times at start/change
// - Emitter lockout shows its error code
// - Receiver led: green on (blinking with reduced resolution), red off, blink red lockout
module light_screen_ctrl #(
  parameter int MS_TICK_CYC = lsc_pkg::MS_TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire lsc_pkg::rx_cfg_type i_rx_cfg,
  input wire lsc_pkg::em_cfg_type i_em_cfg,
  input wire logic i_rx_reset_sw,
  input wire logic i_em_reset_sw,
  input wire logic i_beams_blocked,
  input wire logic i_rx_internal_fault,
  input wire logic i_em_internal_fault,
  input wire logic [3:0] i_em_fault_code,
  output logic [1:0] o_safety_output_pair,
  output logic o_aux_out,
  output logic o_rx_lockout,
  output logic o_reduced_resolution_en,
  output logic o_one_channel_monitoring,
  output lsc_pkg::led_type o_rx_led,
  output lsc_pkg::disp_type o_rx_disp,
  output lsc_pkg::led_type o_em_led,
  output lsc_pkg::disp_type o_em_disp,
  output logic o_em_fault,
  output logic o_em_test_block
);
  import lsc_pkg::*;

  typedef struct packed {
    logic [1:0] safety_output_pair;
    logic aux;
    logic lock;
    logic rres;
    logic one_ch;
    led_type rx_led;
    disp_type rx_disp;
    led_type em_led;
    disp_type em_disp;
    logic em_fault;
    logic em_test;
  } out_type;

  typedef struct packed {
    rx_cfg_type cfg_s1;
    rx_cfg_type cfg_s2;
    rx_cfg_type cfg_snap;
    em_cfg_type ecfg_s1;
    em_cfg_type ecfg_s2;
    rx_state_type rx_state;
    em_state_type em_state;
    logic [3:0] rx_err;
    logic [3:0] em_err;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink;
    logic [2:0] rx_flash;
    logic [2:0] em_flash;
    logic rx_scan;
    logic em_scan;
    out_type out;
  } ctrl_state_type;

  ctrl_state_type st_r;
  ctrl_state_type st_nxt;
  logic tick;
  logic rx_closed;
  logic rx_ok;
  logic em_closed;
  logic em_ok;
  logic pair_bad;
  logic live_chg;
  logic trip_sel;
  logic one_ch;
  logic blink_edge;
  logic test_fn;
  logic [3:0] rx_cause;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic rx_cfg_type cfg_key(input rx_cfg_type c);
    cfg_key = c;
    cfg_key.scan = 1'b0;
  endfunction : cfg_key

  function automatic logic [3:0] scan_digit(input logic sel);
    scan_digit = (sel == SW_LEFT) ? DIG_CODE2 : DIG_CODE1;
  endfunction : scan_digit

  function automatic disp_type make_disp(input logic [2:0] flash, input logic scan,
      input logic lock, input logic [3:0] err, input logic [3:0] idle,
      input logic idle_blank, input logic inv);
    make_disp.invert = inv;
    make_disp.err = lock;
    make_disp.digit = idle;
    make_disp.blank = idle_blank;
    if (lock) begin
      make_disp.digit = err;
      make_disp.blank = 1'b0;
    end else if (flash != CODE_FLASH_HALVES) begin
      make_disp.digit = scan_digit(scan);
      make_disp.blank = flash[0];
    end
  endfunction : make_disp

  reset_qualifier #(.TICK_CYC(MS_TICK_CYC)) u_rx_reset (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_switch_closed(i_rx_reset_sw),
    .o_tick(tick),
    .o_closed(rx_closed),
    .o_valid(rx_ok)
  );

  reset_qualifier #(.TICK_CYC(MS_TICK_CYC)) u_em_reset (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_switch_closed(i_em_reset_sw),
    .o_tick(),
    .o_closed(em_closed),
    .o_valid(em_ok)
  );

  assign pair_bad = (st_r.cfg_s2.trip_a != st_r.cfg_s2.trip_b) ||
      (st_r.cfg_s2.reduced_resolution_select_a != st_r.cfg_s2.reduced_resolution_select_b);
  assign live_chg = cfg_key(st_r.cfg_s2) != cfg_key(st_r.cfg_snap);
  assign trip_sel = st_r.cfg_snap.trip_a == SW_LEFT;
  assign one_ch = st_r.cfg_snap.contactor_feedback_mode == SW_LEFT;
  assign test_fn = st_r.ecfg_s2.test_fn == SW_LEFT;
  assign blink_edge = tick && (st_r.blink_cnt == BLINK_W'(BLINK_MS - 1));
  assign rx_cause = i_rx_internal_fault ? ERR_INTERNAL :
                    pair_bad ? ERR_MISMATCH : live_chg ? ERR_LIVE : ERR_NONE;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.cfg_s1 = i_rx_cfg;
    st_nxt.cfg_s2 = st_r.cfg_s1;
    st_nxt.ecfg_s1 = i_em_cfg;
    st_nxt.ecfg_s2 = st_r.ecfg_s1;
    if (tick) begin
      st_nxt.blink_cnt = blink_edge ? '0 : st_r.blink_cnt + 1'b1;
    end
    if (blink_edge) begin
      st_nxt.blink = !st_r.blink;
    end
    // Code display: three on/off flashes, restarted on any scan change
    st_nxt.rx_scan = st_r.cfg_s2.scan;
    st_nxt.em_scan = st_r.ecfg_s2.scan;
    if (st_r.rx_scan != st_r.cfg_s2.scan) begin
      st_nxt.rx_flash = '0;
    end else if (blink_edge && st_r.rx_flash != CODE_FLASH_HALVES) begin
      st_nxt.rx_flash = st_r.rx_flash + 1'b1;
    end
    if (st_r.em_scan != st_r.ecfg_s2.scan) begin
      st_nxt.em_flash = '0;
    end else if (blink_edge && st_r.em_flash != CODE_FLASH_HALVES) begin
      st_nxt.em_flash = st_r.em_flash + 1'b1;
    end

    // Receiver
    unique case (st_r.rx_state)
      RX_PWRUP: begin
        st_nxt.cfg_snap = st_r.cfg_s2;
        if (st_r.rx_flash == CODE_FLASH_HALVES) begin
          if (pair_bad) begin
            st_nxt.rx_state = RX_LOCKOUT;
            st_nxt.rx_err = ERR_MISMATCH;
          end else begin
            st_nxt.rx_state = trip_sel ? RX_RUN : RX_WAIT;
          end
        end
      end
      RX_WAIT: begin
        if (rx_ok && !i_beams_blocked) begin
          st_nxt.rx_state = RX_RUN;
        end
      end
      RX_RUN: begin
        if (i_beams_blocked) begin
          st_nxt.rx_state = trip_sel ? RX_BLOCKED : RX_LATCHED;
        end
      end
      RX_BLOCKED: begin
        if (!i_beams_blocked) begin
          st_nxt.rx_state = RX_RUN;
        end
      end
      RX_LATCHED: begin
        if (rx_ok && !i_beams_blocked) begin
          st_nxt.rx_state = RX_RUN;
        end
      end
      RX_LOCKOUT: begin
        if (rx_ok && !pair_bad && !i_rx_internal_fault) begin
          st_nxt.rx_state = RX_RUN;
          st_nxt.rx_err = ERR_NONE;
          st_nxt.cfg_snap = st_r.cfg_s2;
        end
      end
      default: begin
        st_nxt.rx_state = RX_LOCKOUT;
        st_nxt.rx_err = ERR_INTERNAL;
      end
    endcase
    if (st_r.rx_state != RX_LOCKOUT && rx_cause != ERR_NONE &&
        (st_r.rx_state != RX_PWRUP || i_rx_internal_fault)) begin
      st_nxt.rx_state = RX_LOCKOUT;
      st_nxt.rx_err = rx_cause;
    end

    // Emitter
    unique case (st_r.em_state)
      EM_PWRUP: begin
        if (st_r.em_flash == CODE_FLASH_HALVES) begin
          st_nxt.em_state = EM_RUN;
        end
      end
      EM_RUN: begin
        if (test_fn && em_closed) begin
          st_nxt.em_state = EM_TEST;
        end
      end
      EM_TEST: begin
        if (!(test_fn && em_closed)) begin
          st_nxt.em_state = EM_RUN;
        end
      end
      EM_LOCKOUT: begin
        if (!test_fn && em_ok && !i_em_internal_fault) begin
          st_nxt.em_state = EM_RUN;
          st_nxt.em_err = ERR_NONE;
        end
      end
    endcase
    if (i_em_internal_fault && st_r.em_state != EM_LOCKOUT) begin
      st_nxt.em_state = EM_LOCKOUT;
      st_nxt.em_err = i_em_fault_code;
    end

    // Outputs, registered with the state
    st_nxt.out.safety_output_pair = {2{st_nxt.rx_state == RX_RUN}};
    st_nxt.out.lock = st_nxt.rx_state == RX_LOCKOUT;
    st_nxt.out.rres = st_nxt.cfg_snap.reduced_resolution_select_a == SW_LEFT;
    st_nxt.out.one_ch = st_nxt.cfg_snap.contactor_feedback_mode == SW_LEFT;
    if (!st_nxt.out.one_ch) begin
      st_nxt.out.aux = 1'b0;
    end else if (st_nxt.cfg_snap.auxiliary_output_select == SW_LEFT) begin
      st_nxt.out.aux = st_nxt.out.safety_output_pair[0];
    end else begin
      st_nxt.out.aux = st_nxt.out.lock;
    end
    st_nxt.out.rx_led = '0;
    unique case (st_nxt.rx_state)
      RX_PWRUP: st_nxt.out.rx_led.red = st_nxt.rx_flash == '0;
      RX_LOCKOUT: st_nxt.out.rx_led.red = st_nxt.blink;
      RX_RUN: st_nxt.out.rx_led.green = !st_nxt.out.rres || st_nxt.blink;
      default: st_nxt.out.rx_led.red = 1'b1;
    endcase
    st_nxt.out.rx_disp = make_disp(st_nxt.rx_flash, st_nxt.cfg_s2.scan,
        st_nxt.out.lock, st_nxt.rx_err, trip_sel ? DIG_DASH : DIG_LATCH, 1'b0,
        st_nxt.cfg_snap.invert == SW_LEFT);
    st_nxt.out.em_led = '0;
    unique case (st_nxt.em_state)
      EM_PWRUP: st_nxt.out.em_led.red = st_nxt.em_flash == '0;
      EM_RUN: st_nxt.out.em_led.green = 1'b1;
      EM_TEST: st_nxt.out.em_led.green = st_nxt.blink;
      EM_LOCKOUT: st_nxt.out.em_led.red = st_nxt.blink;
    endcase
    st_nxt.out.em_disp = make_disp(st_nxt.em_flash, st_nxt.ecfg_s2.scan,
        st_nxt.em_state == EM_LOCKOUT, st_nxt.em_err, DIG_DASH, 1'b1, 1'b0);
    st_nxt.out.em_fault = (st_nxt.em_state == EM_LOCKOUT) &&
        (st_nxt.ecfg_s2.fault_en == SW_LEFT);
    st_nxt.out.em_test = st_nxt.em_state == EM_TEST;
  end

  // Power loss is the reset: everything restarts at power-up
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_safety_output_pair = st_r.out.safety_output_pair;
  assign o_aux_out = st_r.out.aux;
  assign o_rx_lockout = st_r.out.lock;
  assign o_reduced_resolution_en = st_r.out.rres;
  assign o_one_channel_monitoring = st_r.out.one_ch;
  assign o_rx_led = st_r.out.rx_led;
  assign o_rx_disp = st_r.out.rx_disp;
  assign o_em_led = st_r.out.em_led;
  assign o_em_disp = st_r.out.em_disp;
  assign o_em_fault = st_r.out.em_fault;
  assign o_em_test_block = st_r.out.em_test;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_pair_lock;
    st_r.rx_state inside {RX_WAIT, RX_RUN, RX_BLOCKED, RX_LATCHED} && pair_bad &&
      !i_rx_internal_fault |=> st_r.rx_state == RX_LOCKOUT && st_r.rx_err == ERR_MISMATCH;
  endproperty
  a_pair_lock: assert property (p_pair_lock) else $error("pair mismatch not locked");

  property p_live_lock;
    st_r.rx_state inside {RX_WAIT, RX_RUN, RX_BLOCKED, RX_LATCHED} && live_chg &&
      !pair_bad && !i_rx_internal_fault |=> o_rx_lockout && st_r.rx_err == ERR_LIVE;
  endproperty
  a_live_lock: assert property (p_live_lock) else $error("live change not locked");

  property p_trip_auto;
    st_r.rx_state == RX_BLOCKED && !i_beams_blocked && rx_cause == ERR_NONE
      |=> o_safety_output_pair == 2'b11;
  endproperty
  a_trip_auto: assert property (p_trip_auto) else $error("trip did not recover");

  property p_latch_hold;
    st_r.rx_state == RX_LATCHED && !rx_ok |=> o_safety_output_pair == 2'b00;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

  property p_scan_ok;
    st_r.rx_state == RX_RUN && $changed(st_r.cfg_s2.scan) && rx_cause == ERR_NONE &&
      !i_beams_blocked |=> st_r.rx_state == RX_RUN ##1 !o_rx_disp.err;
  endproperty
  a_scan_ok: assert property (p_scan_ok) else $error("scan change caused lockout");

  property p_aux_two;
    o_aux_out |-> st_r.cfg_snap.contactor_feedback_mode == SW_LEFT;
  endproperty
  a_aux_two: assert property (p_aux_two) else $error("aux active in two-channel");

  property p_em_fault;
    o_em_fault |-> st_r.em_state == EM_LOCKOUT && st_r.ecfg_s2.fault_en == SW_LEFT;
  endproperty
  a_em_fault: assert property (p_em_fault) else $error("emitter fault misdriven");

  property p_lock_stay;
    o_rx_lockout && !rx_ok |=> o_rx_lockout && o_safety_output_pair == 2'b00;
  endproperty
  a_lock_stay: assert property (p_lock_stay) else $error("lockout left without reset");

  property p_rx_led;
    o_safety_output_pair == 2'b11 |-> !o_rx_led.red && !o_rx_disp.err;
  endproperty
  a_rx_led: assert property (p_rx_led) else $error("led red while outputs on");

  c_trip_recover: cover property (st_r.rx_state == RX_BLOCKED ##1 st_r.rx_state == RX_RUN);
  c_latch_reset: cover property (st_r.rx_state == RX_LATCHED ##1 st_r.rx_state == RX_RUN);
  c_lock_exit: cover property (st_r.rx_state == RX_LOCKOUT ##1 st_r.rx_state == RX_RUN);
  c_em_test: cover property (st_r.em_state == EM_TEST);
endmodule : light_screen_ctrl
`default_nettype wire

//--- rtl/lsc_pkg.sv
// Constants and carrier types for the light screen control block
package lsc_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int MS_TICK_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 15;
  localparam int RST_MIN_MS = 250;
  localparam int RST_MAX_MS = 2000;
  localparam int HOLD_W = 12;
  localparam int DEB_MS = 10;
  localparam int DEB_W = 5;
  localparam int BLINK_MS = 250;
  localparam int BLINK_W = 8;
  localparam logic [2:0] CODE_FLASH_HALVES = 3'h6;

  // ************************************************************
  // Selector, display and error encodings
  // ************************************************************
  localparam logic SW_LEFT = 1'b1;
  localparam logic [3:0] DIG_CODE1 = 4'h1;
  localparam logic [3:0] DIG_CODE2 = 4'h2;
  localparam logic [3:0] DIG_DASH = 4'hA;
  localparam logic [3:0] DIG_LATCH = 4'hB;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_MISMATCH = 4'h1;
  localparam logic [3:0] ERR_LIVE = 4'h2;
  localparam logic [3:0] ERR_INTERNAL = 4'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    RX_PWRUP = 3'b000, RX_WAIT = 3'b001, RX_RUN = 3'b010,
    RX_BLOCKED = 3'b011, RX_LATCHED = 3'b100, RX_LOCKOUT = 3'b101
  } rx_state_type;
  typedef enum logic [1:0] {
    EM_PWRUP = 2'b00, EM_RUN = 2'b01, EM_TEST = 2'b10, EM_LOCKOUT = 2'b11
  } em_state_type;
  typedef struct packed {
    logic trip_a;
    logic trip_b;
    logic reduced_resolution_select_a;
    logic reduced_resolution_select_b;
    logic scan;
    logic contactor_feedback_mode;
    logic auxiliary_output_select;
    logic invert;
  } rx_cfg_type;
  typedef struct packed {
    logic scan;
    logic test_fn;
    logic fault_en;
  } em_cfg_type;
  typedef struct packed {
    logic red;
    logic green;
  } led_type;
  typedef struct packed {
    logic blank;
    logic err;
    logic [3:0] digit;
    logic invert;
  } disp_type;
  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic sync1;
    logic sync2;
    logic deb;
    logic [DEB_W-1:0] deb_cnt;
    logic [HOLD_W-1:0] hold_ms;
    logic valid;
  } rq_state_type;
endpackage : lsc_pkg

//--- rtl/reset_qualifier.sv
// Reset switch synchroniser, debouncer and closure-duration qualifier
`timescale 1ns/10ps
`default_nettype none
module reset_qualifier #(
  parameter int TICK_CYC = lsc_pkg::MS_TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_switch_closed,
  output logic o_tick,
  output logic o_closed,
  output logic o_valid
);
  import lsc_pkg::*;

  rq_state_type st_r;
  rq_state_type st_nxt;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = i_switch_closed;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.tick = 1'b0;
    st_nxt.valid = 1'b0;
    if (st_r.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end
    // Level must stay changed for the debounce time before it is taken
    if (st_r.sync2 == st_r.deb) begin
      st_nxt.deb_cnt = '0;
    end else if (st_r.tick) begin
      if (st_r.deb_cnt == DEB_W'(DEB_MS - 1)) begin
        st_nxt.deb = st_r.sync2;
        st_nxt.deb_cnt = '0;
      end else begin
        st_nxt.deb_cnt = st_r.deb_cnt + 1'b1;
      end
    end
    // Closure time in ms, saturating just past the longest allowed hold
    if (!st_r.deb) begin
      st_nxt.hold_ms = '0;
    end else if (st_r.tick && st_r.hold_ms <= HOLD_W'(RST_MAX_MS)) begin
      st_nxt.hold_ms = st_r.hold_ms + 1'b1;
    end
    // Act on opening; too long a closure gives nothing
    if (st_r.deb && !st_nxt.deb) begin
      st_nxt.valid = (st_r.hold_ms >= HOLD_W'(RST_MIN_MS)) &&
                     (st_r.hold_ms <= HOLD_W'(RST_MAX_MS));
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;
  assign o_closed = st_r.deb;
  assign o_valid = st_r.valid;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_long_ignored;
    st_r.deb && !st_nxt.deb && st_r.hold_ms > HOLD_W'(RST_MAX_MS) |=> !o_valid;
  endproperty
  a_long_ignored: assert property (p_long_ignored) else $error("long closure accepted");

  property p_valid_window;
    o_valid |-> $past(st_r.deb) && !st_r.deb
      && $past(st_r.hold_ms) >= HOLD_W'(RST_MIN_MS)
      && $past(st_r.hold_ms) <= HOLD_W'(RST_MAX_MS);
  endproperty
  a_valid_window: assert property (p_valid_window) else $error("reset outside window");

  c_valid: cover property (o_valid);
endmodule : reset_qualifier
`default_nettype wire

//--- verification/reset_switch_model.sv
// Operator reset switch model: closes for a requested time, then opens
`timescale 1ns/10ps
`default_nettype none
module reset_switch_model #(
  parameter int MS_TICK_CYC = 5
) (
  input wire logic i_core_clk,
  input wire logic i_press,
  input wire logic [11:0] i_ms,
  output logic o_closed
);
  int unsigned left_cyc = 0;
  always @(posedge i_core_clk) begin
    if (i_press && left_cyc == 0) begin
      left_cyc <= int'(i_ms) * MS_TICK_CYC;
    end else if (left_cyc != 0) begin
      left_cyc <= left_cyc - 1;
    end
  end
  // Open contact reads as 0: the switch line has a defined released level
  assign o_closed = (left_cyc != 0);
endmodule : reset_switch_model
`default_nettype wire

//--- verification/test_light_screen_config_reset_ctrl.sv
// Self-checking bench for the light screen configuration and reset control
`timescale 1ns/10ps
`default_nettype none
module test_light_screen_config_reset_ctrl;
  import lsc_pkg::*;
  localparam int TICK = 5;
  localparam int TIMEOUT = 60000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  rx_cfg_type rx_cfg = 8'hC7;
  em_cfg_type em_cfg = 3'h1;
  logic blocked = 1'b0;
  logic rx_fault = 1'b0;
  logic em_fault = 1'b0;
  logic rx_press = 1'b0;
  logic em_press = 1'b0;
  logic [11:0] press_ms = 12'h000;
  logic rx_sw;
  logic em_sw;
  logic [1:0] safety_output_pair;
  logic aux;
  logic lock;
  logic rr_en;
  logic one_ch;
  led_type rx_led;
  disp_type rx_disp;
  disp_type em_disp;
  led_type em_led;
  logic em_test;
  logic em_flt;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #20 core_clk = ~core_clk;

  light_screen_ctrl #(.MS_TICK_CYC(TICK)) i_dut (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_rx_cfg(rx_cfg), .i_em_cfg(em_cfg),
    .i_rx_reset_sw(rx_sw), .i_em_reset_sw(em_sw), .i_beams_blocked(blocked),
    .i_rx_internal_fault(rx_fault), .i_em_internal_fault(em_fault),
    .i_em_fault_code(4'h5), .o_safety_output_pair(safety_output_pair), .o_aux_out(aux),
    .o_rx_lockout(lock), .o_reduced_resolution_en(rr_en),
    .o_one_channel_monitoring(one_ch), .o_rx_led(rx_led), .o_rx_disp(rx_disp),
    .o_em_led(em_led), .o_em_disp(em_disp), .o_em_fault(em_flt),
    .o_em_test_block(em_test));
  reset_switch_model #(.MS_TICK_CYC(TICK)) i_rx_switch (
    .i_core_clk(core_clk), .i_press(rx_press), .i_ms(press_ms), .o_closed(rx_sw));
  reset_switch_model #(.MS_TICK_CYC(TICK)) i_em_switch (
    .i_core_clk(core_clk), .i_press(em_press), .i_ms(press_ms), .o_closed(em_sw));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : step

  task automatic wait_ms(input int ms);
    step(ms * TICK);
  endtask : wait_ms

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic power_up(input logic [7:0] cfg);
    rst_n = 1'b0;
    rx_cfg = cfg;
    step(12);
    rst_n = 1'b1;
    wait_ms(1600);
  endtask : power_up

  task automatic press(input logic em, input logic [11:0] ms);
    rx_press = !em;
    em_press = em;
    press_ms = ms;
    step(1);
    rx_press = 1'b0;
    em_press = 1'b0;
    step(1);
    while (rx_sw || em_sw) step(1);
    wait_ms(20);
  endtask : press

  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      num_errors++;
      results();
    end
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    // Trip, one channel, aux follows outputs, inverted display
    power_up(8'hC7);
    chk(4'(safety_output_pair), 4'h3);
    chk(4'(rx_led), 4'h1);
    chk(4'(aux), 4'h1);
    chk(4'(one_ch), 4'h1);
    chk(4'(rr_en), 4'h0);
    chk(4'(rx_disp.invert), 4'h1);
    chk(rx_disp.digit, DIG_DASH);
    blocked = 1'b1;
    wait_ms(1);
    chk(4'(safety_output_pair), 4'h0);
    chk(4'(rx_led), 4'h2);
    chk(4'(aux), 4'h0);
    blocked = 1'b0;
    wait_ms(1);
    chk(4'(safety_output_pair), 4'h3);
    // Scan code change in run is accepted on both ends
    rx_cfg = 8'hCF;
    em_cfg = 3'h5;
    wait_ms(1);
    chk(4'(lock), 4'h0);
    chk(4'(safety_output_pair), 4'h3);
    // Live change of aux select locks out
    rx_cfg = 8'hCD;
    wait_ms(1);
    chk(4'(lock), 4'h1);
    chk(4'(safety_output_pair), 4'h0);
    press(1'b0, 12'h834);
    chk(4'(lock), 4'h1);
    press(1'b0, 12'h064);
    chk(4'(lock), 4'h1);
    press(1'b0, 12'h12C);
    chk(4'(lock), 4'h0);
    chk(4'(safety_output_pair), 4'h3);
    chk(4'(aux), 4'h0);
    // Power cycle with disagreeing trip pair
    power_up(8'h8D);
    chk(4'(lock), 4'h1);
    chk(4'(safety_output_pair), 4'h0);
    // Latch operation
    power_up(8'h0D);
    chk(4'(lock), 4'h0);
    chk(4'(safety_output_pair), 4'h0);
    press(1'b0, 12'h12C);
    chk(4'(safety_output_pair), 4'h3);
    blocked = 1'b1;
    wait_ms(1);
    blocked = 1'b0;
    wait_ms(1);
    chk(4'(safety_output_pair), 4'h0);
    press(1'b0, 12'h12C);
    chk(4'(safety_output_pair), 4'h3);
    // Emitter internal failure with fault enable on
    em_fault = 1'b1;
    step(1);
    em_fault = 1'b0;
    wait_ms(1);
    chk(4'(em_flt), 4'h1);
    chk(4'(em_disp.err), 4'h1);
    press(1'b1, 12'h12C);
    chk(4'(em_flt), 4'h0);
    chk(4'(em_led), 4'h1);
    // Emitter test input simulates a blocked receiver while held
    em_cfg = 3'h7;
    em_press = 1'b1;
    press_ms = 12'h064;
    step(1);
    em_press = 1'b0;
    wait_ms(30);
    chk(4'(em_test), 4'h1);
    chk(4'(em_led.red), 4'h0);
    wait_ms(100);
    chk(4'(em_test), 4'h0);
    chk(4'(em_led), 4'h1);
    results();
  end
endmodule : test_light_screen_config_reset_ctrl
`default_nettype wire
